/* File: dv/sibhp_bus_assertions.sv */
// Assertions on the bus wires.
// Assumes one core clock.
`timescale 1ns/1ps
module sibhp_bus_assertions #(
  parameter int REF_CYC = 300 // Refresh spacing in core cycles
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic aen,
  input wire logic bale,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic [19:0] sa,
  input wire logic [7:0] dack_n,
  input wire logic tc,
  input wire logic refresh_n,
  input wire logic resetdrv,
  input wire logic sysclk_oe,
  input wire logic iochrdy
);
  // ****
  // Helpers
  // ****
  wire logic strb = !(ior_n & iow_n & memr_n & memw_n); // Any command strobe low
  logic [15:0] gap; // Cycles since the last refresh
  logic [15:0] next_gap;
  // Counts cycles since refresh
  always_comb next_gap = refresh_n ? gap + 16'h0001 : 16'h0000;
  always_ff @(posedge core_clk_in or posedge reset_in)
    if (reset_in)
      gap <= 16'h0000;
    else
      gap <= next_gap;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_addr;
    bale [*6] ##1 !bale;
  endsequence
  sequence s_cmd;
    strb [*8];
  endsequence
  // ****
  // Properties
  // ****
  a_addr_phase: assert property ($rose(bale) |-> s_addr)
    else $error("bale length");
  a_addr_hold: assert property (bale && $past(bale) |-> $stable(sa))
    else $error("sa moved");
  a_cmd_width: assert property ($rose(strb) && refresh_n |-> s_cmd)
    else $error("strobe short");
  a_wait_hold: assert property (strb && !iochrdy |=> strb)
    else $error("ready ignored");
  a_aen_on_ack: assert property (dack_n != 8'hFF |-> aen)
    else $error("dack without aen");
  a_ack_chan: assert property (dack_n != 8'hFF |-> dack_n == 8'hDF)
    else $error("wrong dack");
  a_tc_in_dma: assert property (tc |-> aen && !dack_n[5])
    else $error("stray tc");
  a_quiet_reset: assert property ($rose(strb) && refresh_n |-> !resetdrv)
    else $error("cycle in reset");
  a_refresh_due: assert property (gap < 16'(REF_CYC + 40))
    else $error("refresh overdue");
  a_clk_gate: assert property (strb |-> sysclk_oe)
    else $error("sysclk off");
endmodule : sibhp_bus_assertions

/* File: dv/testbench.sv */
// Self-checking bench: host and board on one bus.
// Inputs change on falling edges.
`timescale 1ns/1ps
module testbench;
  // ****
  // Signals
  // ****
  logic core_clk_in = 1'b0, reset_in = 1'b1, ce_in = 1'b1; // Clock, reset, run
  logic req_in = 1'b0, word_in = 1'b1, dma_req_in = 1'b0, dma_dir_in = 1'b1; // Requests
  logic irq_req_in = 1'b0, irq_clear_in = 1'b0, irq_ack_in = 1'b0; // Interrupt controls
  logic err_in = 1'b0, err_clear_in = 1'b0, soft_reset_in = 1'b0; // Error and reset
  sibhp_pkg::sibhp_cmd_t kind_in = sibhp_pkg::CY_MEMR; // Cycle kind
  logic [23:0] addr_in = 24'h000000, dma_addr_in = 24'h0D0000; // Addresses
  logic [15:0] wdata_in = 16'h0000, dma_len_in = 16'h0002, dma_data_in = 16'h1234; // Short DMA block
  logic busy_out, done_out, wide_out, irq_valid_out, err_out, wr_pulse_out; // Flags
  logic [15:0] rdata_out, dma_data_out, wr_data_out, wr_dat_q; // Data seen
  logic [3:0] irq_num_out; // Served line
  logic [1:0] wr_index_out, wr_idx_q; // Write index
  logic got_wr = 1'b0, seen_tc; // Write landed; tc seen
  int n_fail = 0, tests_run = 0, i, n;
  sibhp_bus_if bus();
  sibhp_host #(.REF_CYC(40), .RST_N(4)) sibhp_host_inst (.*);
  sibhp_dev sibhp_dev_inst (.*);
  sibhp_bus_assertions #(.REF_CYC(40)) sibhp_bus_assertions_inst (.core_clk_in, .reset_in, .aen(bus.aen),
    .bale(bus.bale), .ior_n(bus.ior_n), .iow_n(bus.iow_n), .memr_n(bus.memr_n), .memw_n(bus.memw_n),
    .sa(bus.sa), .dack_n(bus.dack_n), .tc(bus.tc), .refresh_n(bus.refresh_n), .resetdrv(bus.resetdrv),
    .sysclk_oe(bus.sysclk_oe), .iochrdy(bus.iochrdy));
  always #25 core_clk_in = ~core_clk_in; // 20 MHz core clock
  // Latch the one-cycle write report
  always @(posedge core_clk_in)
    if (wr_pulse_out === 1'b1)
    begin
      got_wr = 1'b1;
      wr_idx_q = wr_index_out;
      wr_dat_q = wr_data_out;
    end
  // ****
  // Tasks
  // ****
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Timed-out wait ends the run
  task automatic give_up(input bit ok);
    if (!ok)
    begin
      n_fail++;
      tally_and_finish();
    end
  endtask : give_up
  // Hold request until our own cycle starts
  task automatic bus_op(input sibhp_pkg::sibhp_cmd_t k, input logic [23:0] a, input logic [15:0] d);
    kind_in = k;
    addr_in = a;
    wdata_in = d;
    req_in = 1'b1;
    for (i = 0; i < 200 && !(busy_out === 1'b1 && bus.refresh_n === 1'b1); i++) @(negedge core_clk_in);
    req_in = 1'b0;
    for (i = 0; i < 400 && done_out !== 1'b1; i++) @(negedge core_clk_in);
    give_up(done_out === 1'b1);
  endtask : bus_op
  task automatic rd_chk(input sibhp_pkg::sibhp_cmd_t k, input logic [23:0] a, input logic [15:0] m,
    input logic [15:0] exp, input logic w);
    bus_op(k, a, 16'h0000);
    check("read data", rdata_out & m, exp);
    check("word width", {15'h0000, wide_out}, {15'h0000, w});
  endtask : rd_chk
  task automatic wr_chk(input sibhp_pkg::sibhp_cmd_t k, input logic [23:0] a, input logic [15:0] d,
    input logic [1:0] idx);
    got_wr = 1'b0;
    bus_op(k, a, d);
    for (i = 0; i < 20 && !got_wr; i++) @(negedge core_clk_in);
    check("write data", wr_dat_q, d);
    check("write index", {14'h0000, wr_idx_q}, {14'h0000, idx});
  endtask : wr_chk
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (10) @(negedge core_clk_in);
    reset_in = 1'b0;
    wr_chk(sibhp_pkg::CY_IOW, 24'h000300, 16'hA55A, 2'h0);
    rd_chk(sibhp_pkg::CY_IOR, 24'h000300, 16'hFFFF, 16'hA55A, 1'b1);
    wr_chk(sibhp_pkg::CY_MEMW, 24'h0D0004, 16'h5AA5, 2'h2);
    rd_chk(sibhp_pkg::CY_MEMR, 24'h0D0004, 16'hFFFF, 16'h5AA5, 1'b1);
    rd_chk(sibhp_pkg::CY_MEMR, 24'h1D0004, 16'h00FF, 16'h00FF, 1'b0);
    rd_chk(sibhp_pkg::CY_IOR, 24'h000310, 16'h00FF, 16'h00FF, 1'b0);
    // Two-long DMA block, one each way
    for (n = 0; n < 2; n++)
    begin
      seen_tc = 1'b0;
      dma_dir_in = (n == 0);
      dma_req_in = 1'b1;
      @(negedge core_clk_in);
      dma_req_in = 1'b0;
      for (i = 0; i < 200 && bus.dack_n[5] !== 1'b0; i++) @(negedge core_clk_in);
      give_up(bus.dack_n[5] === 1'b0);
      for (i = 0; i < 200 && bus.dack_n[5] !== 1'b1; i++)
      begin
        seen_tc = seen_tc | (bus.tc === 1'b1);
        @(negedge core_clk_in);
      end
      check("terminal count", {15'h0000, seen_tc}, {15'h0000, n == 1});
      if (n == 0) check("dma read", rdata_out, dma_data_in);
    end
    irq_req_in = 1'b1;
    @(negedge core_clk_in);
    irq_req_in = 1'b0;
    for (i = 0; i < 20 && irq_valid_out !== 1'b1; i++) @(negedge core_clk_in);
    check("irq line", {12'h000, irq_num_out}, 16'h000A);
    irq_ack_in = 1'b1;
    irq_clear_in = 1'b1;
    @(negedge core_clk_in);
    irq_ack_in = 1'b0;
    irq_clear_in = 1'b0;
    check("irq pending", {15'h0000, irq_valid_out}, 16'h0000);
    err_in = 1'b1;
    for (i = 0; i < 20 && err_out !== 1'b1; i++) @(negedge core_clk_in);
    check("error flag", {15'h0000, err_out}, 16'h0001);
    err_in = 1'b0;
    err_clear_in = 1'b1;
    @(negedge core_clk_in);
    err_clear_in = 1'b0;
    @(negedge core_clk_in);
    check("error cleared", {15'h0000, err_out}, 16'h0000);
    soft_reset_in = 1'b1;
    @(negedge core_clk_in);
    soft_reset_in = 1'b0;
    for (i = 0; i < 100 && bus.resetdrv !== 1'b1; i++) @(negedge core_clk_in);
    check("bus reset", {15'h0000, bus.resetdrv}, 16'h0001);
    rd_chk(sibhp_pkg::CY_IOR, 24'h000300, 16'hFFFF, 16'hA55A, 1'b1);
    tally_and_finish();
  end
endmodule : testbench

/* File: rtl/sibhp_dev.sv */
// Board end: 16-bit registers in I/O and memory space.
// Assumes the host port; bus pins are resynchronised.
`timescale 1ns/1ps
module sibhp_dev #(
  parameter logic [15:0] IO_BASE = 16'h0300, // I/O window base, eight bytes
  parameter logic [23:0] MEM_BASE = 24'h0D0000, // Memory window base, eight bytes
  parameter int WAIT_CYC = 4, // Ready held low this long per strobe
  parameter bit IS16 = 1'b1, // Board claims a 16-bit path
  parameter bit ZWS = 1'b0, // Board asks for zero-wait cycles
  parameter int DMA_CH = 5, // DMA channel used
  parameter int IRQ_LINE = 10 // Interrupt line used
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  sibhp_bus_if.dev bus,
  input wire logic dma_req_in,
  input wire logic [15:0] dma_data_in,
  output logic [15:0] dma_data_out,
  input wire logic irq_req_in,
  input wire logic irq_clear_in,
  input wire logic err_in,
  output logic wr_pulse_out,
  output logic [1:0] wr_index_out,
  output logic [15:0] wr_data_out
);
  localparam int SW = 51; // Synchronised pin count
  localparam logic [SW-1:0] IDLE = {27'h0000000, 5'h1F, 1'h0, 2'h3, 16'hFFFF}; // Quiet bus, so no false strobe
  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  logic [SW-1:0] s1, s2; // First and second stages
  logic [SW-1:0] pins; // Raw pin vector
  assign pins = {bus.sa, bus.la, bus.sbhe_n, bus.memr_n, bus.memw_n, bus.ior_n, bus.iow_n, bus.aen,
    bus.dack_n[DMA_CH], bus.resetdrv, bus.sd};
  // Two stages, only the second is read
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s1 <= IDLE;
      s2 <= IDLE;
    end
    else if (ce_in)
    begin
      s1 <= pins;
      s2 <= s1;
    end
  end
  logic [19:0] sa; // Synced address
  logic [23:17] la; // Synced upper address
  logic sbhe_n, memr_n, memw_n, ior_n, iow_n, aen, dack_n, rstdrv; // Synced controls
  logic [15:0] sd; // Synced data
  assign {sa, la, sbhe_n, memr_n, memw_n, ior_n, iow_n, aen, dack_n, rstdrv, sd} = s2;
  // ************************************************************
  // Decode
  // ************************************************************
  logic io_hit, mem_hit, rd, wr, dma_rd, dma_wr, act; // Decoded cycle kinds
  logic [23:0] full; // Full memory address from both groups
  assign full = {la, sa[16:0]};
  assign io_hit = ~aen & (sa[15:3] == IO_BASE[15:3]);
  assign mem_hit = ~aen & (full[23:3] == MEM_BASE[23:3]);
  assign rd = (io_hit & ~ior_n) | (mem_hit & ~memr_n);
  assign wr = (io_hit & ~iow_n) | (mem_hit & ~memw_n);
  assign dma_rd = ~dack_n & ~ior_n;
  assign dma_wr = ~dack_n & ~iow_n;
  assign act = rd | wr | dma_rd | dma_wr;
  // ************************************************************
  // Board state
  // ************************************************************
  logic [15:0] regs [4]; // Register window
  logic [15:0] next_reg; // Value for the addressed entry
  logic [2:0] wadr; // Write address held for the strobe end
  logic [2:0] next_wadr;
  logic act_d, next_act_d; // Strobe seen last cycle
  logic wr_d, next_wr_d; // Write seen last cycle
  logic dwr_d, next_dwr_d; // DMA write seen last cycle
  logic [7:0] wcnt, next_wcnt; // Wait-state counter
  logic drq, next_drq; // DMA request level
  logic irq, next_irq; // Interrupt request level
  logic [15:0] rdo, next_rdo; // Read data driven
  logic [15:0] dmo, next_dmo; // DMA data captured
  logic wp, next_wp; // Write pulse to user
  logic [15:0] wdat, next_wdat; // Captured write data
  // Writes land at strobe end, once data has settled
  always_comb
  begin
    next_act_d = act;
    next_wr_d = wr;
    next_dwr_d = dma_wr;
    next_wadr = wr ? sa[2:0] : wadr;
    next_wdat = (wr | dma_wr) ? sd : wdat;
    next_wp = wr_d & ~wr;
    next_reg = regs[wadr[2:1]];
    if (wadr[0] | ~sbhe_n)
      next_reg[15:8] = wadr[0] ? wdat[7:0] : wdat[15:8];
    if (~wadr[0])
      next_reg[7:0] = wdat[7:0];
    next_dmo = (dwr_d & ~dma_wr) ? wdat : dmo;
    // Ready pulled low from the second strobe cycle, once the counter is loaded
    if (act & ~act_d)
      next_wcnt = 8'(WAIT_CYC);
    else if (wcnt != 8'h00)
      next_wcnt = wcnt - 8'h01;
    else
      next_wcnt = wcnt;
    next_rdo = dma_rd ? dma_data_in : (sa[0] ? {8'h00, regs[sa[2:1]][15:8]} : regs[sa[2:1]]);
    // Request held until acknowledged; a new request wins over the clear
    next_drq = dma_req_in | (drq & dack_n);
    next_irq = irq_req_in | (irq & ~irq_clear_in);
  end
  // Register stage; bus reset clears the write, DMA and interrupt requests only
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      act_d <= 1'b0;
      wr_d <= 1'b0;
      dwr_d <= 1'b0;
      wadr <= 3'h0;
      wcnt <= 8'h00;
      drq <= 1'b0;
      irq <= 1'b0;
      rdo <= 16'h0000;
      dmo <= 16'h0000;
      wp <= 1'b0;
      wdat <= 16'h0000;
      for (int i = 0; i < 4; i++)
        regs[i] <= 16'h0000;
    end
    else if (ce_in)
    begin
      act_d <= next_act_d;
      wr_d <= rstdrv ? 1'b0 : next_wr_d;
      dwr_d <= next_dwr_d;
      wadr <= next_wadr;
      wcnt <= next_wcnt;
      drq <= rstdrv ? 1'b0 : next_drq;
      irq <= rstdrv ? 1'b0 : next_irq;
      rdo <= next_rdo;
      dmo <= next_dmo;
      wp <= next_wp;
      wdat <= next_wdat;
      if (next_wp)
        regs[wadr[2:1]] <= next_reg;
    end
  end
  // ************************************************************
  // Pin drives
  // ************************************************************
  assign bus.d_sd_o = rdo;
  assign bus.d_sd_oe = rd | dma_rd;
  assign bus.rdy_oe = act & (wcnt != 8'h00);
  assign bus.endxfr_oe = ZWS & IS16 & act;
  assign bus.iocs16_n = ~(IS16 & io_hit);
  assign bus.memcs16_n = ~(IS16 & mem_hit);
  assign bus.master_n = 1'b1; // Board never takes the bus
  assign bus.chck_n = ~err_in;
  assign bus.drq = 8'(drq) << DMA_CH;
  assign bus.irq = 14'(irq) << (IRQ_LINE - sibhp_pkg::IRQ_LO);
  assign dma_data_out = dmo;
  assign wr_pulse_out = wp;
  assign wr_index_out = wadr[2:1];
  assign wr_data_out = wdat;
endmodule : sibhp_dev

/* File: rtl/sibhp_host.sv */
// Host port: runs processor, DMA and refresh cycles.
// Assumes one board interface; bus inputs resynchronised.
// Contract
// - Address enable high only in DMA cycles
// - Latch enable only while address valid
// - DMA request held until acknowledged
// - Highest-numbered DMA request served first
// - End-transfer ends 16-bit cycle at once
// - Low ready line adds wait states
// - I/O 16-bit select makes word cycle
// - Memory 16-bit select makes word cycle
// - Interrupts held high, caught on rise
// - Line fifteen highest, down to two
// - Upper lines pick 128K window
// - Memory boards decode full address
// - Free-running 14.31818 MHz oscillator output; the accumulator at the 20 MHz core clock aliases it to about 5.68 MHz
// - Refresh cycle every 15 microseconds
// - Bus reset at power-on and command
// - Twenty latched address lines, bit zero low
// - Two data bytes, high enable marks high
// - I/O read board drives, write host drives
// - 8 MHz system clock only during cycles
// - Terminal count pulses on final DMA cycle
// - Master input during DMA cycles makes host release lines
// - Channel check raises an error flag
`timescale 1ns/1ps
module sibhp_host #(
  parameter int REF_CYC = sibhp_pkg::REFRESH_CYC, // Refresh spacing in cycles
  parameter int ADDR_N = sibhp_pkg::ADDR_CYC, // Address phase length
  parameter int CMD_N = sibhp_pkg::CMD_CYC, // Least strobe length
  parameter int RST_N = sibhp_pkg::RESETDRV_CYC // Bus reset stretch
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  sibhp_bus_if.host bus,
  input wire logic req_in,
  input wire sibhp_pkg::sibhp_cmd_t kind_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic word_in,
  output logic busy_out,
  output logic done_out,
  output logic wide_out,
  output logic [15:0] rdata_out,
  input wire logic dma_dir_in,
  input wire logic [23:0] dma_addr_in,
  input wire logic [15:0] dma_len_in,
  output logic irq_valid_out,
  output logic [3:0] irq_num_out,
  input wire logic irq_ack_in,
  output logic err_out,
  input wire logic err_clear_in,
  input wire logic soft_reset_in
);
  import sibhp_pkg::*;
  localparam int SW = 44; // Synchronised input count
  localparam logic [SW-1:0] IDLE = {6'h3F, 22'h000000, 16'hFFFF}; // Requests low: no false rise
  // ************************************************************
  // Input synchroniser
  // ************************************************************
  logic [SW-1:0] s1, s2; // Stages; only s2 is read
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s1 <= IDLE;
      s2 <= IDLE;
    end
    else if (ce_in)
    begin
      s1 <= {bus.iochrdy, bus.iocs16_n, bus.memcs16_n, bus.endxfr_n, bus.master_n, bus.chck_n,
        bus.irq, bus.drq, bus.sd};
      s2 <= s1;
    end
  end
  logic rdy, io16_n, mem16_n, endx_n, mst_n, chck_n; // Synced status
  logic [15:2] irq; // Synced interrupt lines
  logic [7:0] drq; // Synced DMA requests
  logic [15:0] sd; // Synced data
  assign {rdy, io16_n, mem16_n, endx_n, mst_n, chck_n, irq, drq, sd} = s2;
  // ************************************************************
  // Cycle state
  // ************************************************************
  sibhp_state_t state, next_state; // Bus cycle sequencer
  sibhp_cmd_t cmd, next_cmd; // Cycle kind; I/O side for DMA
  sibhp_owner_t own, next_own; // Who owns the cycle
  logic [23:0] adr, next_adr; // Cycle address
  logic [15:0] wd, next_wd; // Write data
  logic word, next_word; // Word wanted
  logic wide, next_wide; // Word granted
  logic [7:0] cnt, next_cnt; // Phase counter
  logic [2:0] ch, next_ch; // Served DMA channel
  logic [15:0] dcnt, next_dcnt; // DMA transfers done
  logic [15:0] rd, next_rd; // Read data
  logic done, next_done; // Completion pulse
  logic [15:0] rcnt, next_rcnt; // Refresh timer
  logic rdue, next_rdue; // Refresh owed
  logic [7:0] row, next_row; // Refresh row
  logic [2:0] hi_ch; // Highest pending DMA channel
  logic dlast; // Final DMA transfer
  logic cmd_ok; // Least strobe width reached
  always_comb
  begin
    hi_ch = 3'h0;
    for (int i = 0; i < DMA_N; i++)
      if (drq[i])
        hi_ch = 3'(i);
  end
  assign dlast = (dcnt == dma_len_in - 16'h0001);
  assign cmd_ok = (cnt >= 8'(CMD_N - 1));
  // Sequencer: refresh first, then DMA, then processor requests
  always_comb
  begin
    next_state = state;
    next_cmd = cmd;
    next_own = own;
    next_adr = adr;
    next_wd = wd;
    next_word = word;
    next_wide = wide;
    next_cnt = (cnt == 8'hFF) ? cnt : cnt + 8'h01;
    next_ch = ch;
    next_dcnt = dcnt;
    next_rd = rd;
    next_done = 1'b0;
    next_row = row;
    next_rcnt = (rcnt == 16'(REF_CYC - 1)) ? 16'h0000 : rcnt + 16'h0001;
    next_rdue = rdue | (rcnt == 16'(REF_CYC - 1));
    case (state)
      ST_IDLE:
      begin
        next_cnt = 8'h00;
        if (bus.resetdrv)
          next_state = ST_IDLE; // Held in bus reset
        else if (rdue)
        begin
          next_own = OWN_REF;
          next_cmd = CY_MEMR;
          next_adr = {16'h0000, row};
          next_word = 1'b0;
          next_row = row + 8'h01;
          next_rdue = (rcnt == 16'(REF_CYC - 1)); // A new tick in this cycle stays owed
          next_state = ST_ADDR;
        end
        else if (|drq)
        begin
          next_own = OWN_DMA;
          next_ch = hi_ch;
          next_cmd = dma_dir_in ? CY_IOR : CY_IOW;
          next_adr = dma_addr_in;
          next_word = (hi_ch >= 3'(DMA16_LO));
          next_state = ST_ADDR;
        end
        else if (req_in)
        begin
          next_own = OWN_CPU;
          next_cmd = kind_in;
          next_adr = addr_in;
          next_wd = addr_in[0] ? {wdata_in[7:0], wdata_in[7:0]} : wdata_in;
          next_word = word_in & ~addr_in[0];
          next_state = ST_ADDR;
        end
      end
      ST_ADDR:
      begin
        if (cnt == 8'(ADDR_N - 1))
        begin
          // Width fixed at phase end by the select line, or by the channel for DMA
          if (cmd == CY_IOR || cmd == CY_IOW)
            next_wide = word & ~io16_n;
          else
            next_wide = word & ~mem16_n;
          if (own == OWN_DMA)
            next_wide = word;
          next_cnt = 8'h00;
          next_state = ST_CMD;
        end
      end
      ST_CMD:
      begin
        // End-transfer skips waits; else least width and ready
        if ((wide & ~endx_n) | (cmd_ok & rdy))
        begin
          next_rd = (wide | ~adr[0]) ? sd : {8'h00, sd[15:8]};
          next_state = ST_END;
        end
      end
      ST_END:
      begin
        next_done = (own == OWN_CPU);
        if (own == OWN_DMA)
          next_dcnt = dlast ? 16'h0000 : dcnt + 16'h0001;
        next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state <= ST_IDLE;
      cmd <= CY_MEMR;
      own <= OWN_CPU;
      adr <= 24'h000000;
      wd <= 16'h0000;
      word <= 1'b0;
      wide <= 1'b0;
      cnt <= 8'h00;
      ch <= 3'h0;
      dcnt <= 16'h0000;
      rd <= 16'h0000;
      done <= 1'b0;
      rcnt <= 16'h0000;
      rdue <= 1'b0;
      row <= 8'h00;
    end
    else if (ce_in)
    begin
      state <= next_state;
      cmd <= next_cmd;
      own <= next_own;
      adr <= next_adr;
      wd <= next_wd;
      word <= next_word;
      wide <= next_wide;
      cnt <= next_cnt;
      ch <= next_ch;
      dcnt <= next_dcnt;
      rd <= next_rd;
      done <= next_done;
      rcnt <= next_rcnt;
      rdue <= next_rdue;
      row <= next_row;
    end
  end
  // ************************************************************
  // Interrupts, channel check, bus reset, bus clocks
  // ************************************************************
  logic [15:2] ipend, next_ipend, iprev; // Pending and last levels
  logic [15:2] iclr; // Served line cleared by acknowledge
  logic eflag, next_eflag, cprev; // Error flag and last check level
  logic [7:0] rstc, next_rstc; // Bus reset stretch
  logic [ACC_W-1:0] oacc, next_oacc, sacc, next_sacc; // Clock phase accumulators
  logic [3:0] inum; // Highest pending line
  always_comb
  begin
    inum = 4'h0;
    for (int i = IRQ_LO; i <= IRQ_HI; i++)
      if (ipend[i])
        inum = 4'(i);
    iclr = '0;
    if (irq_ack_in && ipend[inum])
      iclr[inum] = 1'b1;
    next_ipend = (irq & ~iprev) | (ipend & ~iclr);
    next_eflag = (~chck_n & cprev) | (eflag & ~err_clear_in);
    next_rstc = soft_reset_in ? 8'(RST_N) : ((rstc == 8'h00) ? rstc : rstc - 8'h01);
    next_oacc = oacc + OSC_INC;
    next_sacc = sacc + SYSCLK_INC;
  end
  // Stretch loaded at power-on so bus reset outlasts core reset
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ipend <= '0;
      iprev <= '0;
      eflag <= 1'b0;
      cprev <= 1'b1;
      rstc <= 8'(RST_N);
      oacc <= '0;
      sacc <= '0;
    end
    else if (ce_in)
    begin
      ipend <= next_ipend;
      iprev <= irq;
      eflag <= next_eflag;
      cprev <= chck_n;
      rstc <= next_rstc;
      oacc <= next_oacc;
      sacc <= next_sacc;
    end
  end
  // ************************************************************
  // Pin drives
  // ************************************************************
  logic dma, in_cyc, strobe, mrd, mwr, iord, iowr; // Decoded cycle phases
  assign dma = (own == OWN_DMA) & (state != ST_IDLE);
  assign in_cyc = (state != ST_IDLE);
  assign strobe = (state == ST_CMD);
  assign mrd = strobe & (cmd == CY_MEMR || (dma && cmd == CY_IOW));
  assign mwr = strobe & (cmd == CY_MEMW || (dma && cmd == CY_IOR));
  assign iord = strobe & (cmd == CY_IOR);
  assign iowr = strobe & (cmd == CY_IOW);
  assign bus.aen = dma;
  assign bus.bale = (state == ST_ADDR);
  assign bus.sa = in_cyc ? adr[SA_W-1:0] : 20'h00000;
  assign bus.la = in_cyc ? adr[23:LA_LO] : 7'h00;
  assign bus.sbhe_n = ~(in_cyc & (word | adr[0]));
  assign bus.memr_n = ~mrd;
  assign bus.memw_n = ~mwr;
  assign bus.smemr_n = ~(mrd & (adr[23:20] == MEM1M_TOP));
  assign bus.smemw_n = ~(mwr & (adr[23:20] == MEM1M_TOP));
  assign bus.ior_n = ~(iord & (own != OWN_REF));
  assign bus.iow_n = ~iowr;
  assign bus.dack_n = ~(8'(dma) << ch);
  assign bus.tc = dma & dlast;
  assign bus.refresh_n = ~((own == OWN_REF) & in_cyc);
  assign bus.resetdrv = (rstc != 8'h00);
  assign bus.osc = oacc[ACC_W-1];
  assign bus.sysclk = sacc[ACC_W-1];
  assign bus.sysclk_oe = in_cyc;
  assign bus.bus_oe = ~(dma & ~mst_n);
  assign bus.h_sd_o = wd;
  assign bus.h_sd_oe = (own == OWN_CPU) & (mwr | iowr) & ~(dma & ~mst_n);
  assign busy_out = in_cyc;
  assign done_out = done;
  assign wide_out = wide;
  assign rdata_out = rd;
  assign irq_valid_out = |ipend;
  assign irq_num_out = inum;
  assign err_out = eflag;
endmodule : sibhp_host

/* File: shared/sibhp_bus_if.sv */
// Bus wires between the host port and one peripheral end.
// Assumes pull-ups on data and ready; enables resolve the wires.
`timescale 1ns/1ps
interface sibhp_bus_if;
  logic aen, bale, sbhe_n, memr_n, memw_n, smemr_n, smemw_n, ior_n, iow_n; // Host control lines
  logic [19:0] sa; // Latched address
  logic [23:17] la; // Unlatched address
  logic [7:0] dack_n; // DMA acknowledges
  logic tc, refresh_n, resetdrv, osc, sysclk, sysclk_oe, bus_oe; // Host status and clocks
  logic [15:0] h_sd_o, d_sd_o, sd; // Data drives and resolved data
  logic h_sd_oe, d_sd_oe; // Data enables
  logic rdy_oe, endxfr_oe, iochrdy, endxfr_n; // Open-drain pulls and resolved levels
  logic iocs16_n, memcs16_n, master_n, chck_n; // Peripheral status lines
  logic [15:2] irq; // Interrupt requests
  logic [7:0] drq; // DMA requests
  // Pull-ups win when nobody drives
  assign sd = h_sd_oe ? h_sd_o : (d_sd_oe ? d_sd_o : 16'hFFFF);
  assign iochrdy = ~rdy_oe;
  assign endxfr_n = ~endxfr_oe;
  modport host (output aen, bale, sbhe_n, memr_n, memw_n, smemr_n, smemw_n, ior_n, iow_n, sa, la, dack_n,
    tc, refresh_n, resetdrv, osc, sysclk, sysclk_oe, bus_oe, h_sd_o, h_sd_oe,
    input sd, iochrdy, endxfr_n, iocs16_n, memcs16_n, master_n, chck_n, irq, drq);
  modport dev (input aen, bale, sbhe_n, memr_n, memw_n, ior_n, iow_n, sa, la, dack_n, tc, resetdrv, sd,
    output d_sd_o, d_sd_oe, rdy_oe, endxfr_oe, iocs16_n, memcs16_n, master_n, chck_n, irq, drq);
endinterface : sibhp_bus_if

/* File: shared/sibhp_pkg.sv */
// Constants and types of the bus host port and its board.
// Assumes one 20 MHz core clock for both ends.
package sibhp_pkg;
  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CORE_HZ = 20000000; // Core clock rate
  localparam int REFRESH_NS = 15000; // Refresh cycle spacing in ns
  localparam int REFRESH_CYC = (REFRESH_NS * (CORE_HZ / 1000000)) / 1000; // Cycles between refreshes
  localparam int ADDR_CYC = 6; // Address phase, covers both sync delays of the select lines
  localparam int CMD_CYC = 8; // Least strobe width before ready is trusted
  localparam int RESETDRV_CYC = 20; // Bus reset stretch
  localparam int ACC_W = 24; // Clock accumulator width
  localparam longint OSC_HZ = 64'd14318180; // Oscillator target rate; above half the core clock, so the output aliases to about 5.68 MHz
  localparam longint SYSCLK_HZ = 64'd8000000; // System clock rate
  localparam logic [ACC_W-1:0] OSC_INC = ACC_W'((OSC_HZ << ACC_W) / CORE_HZ); // Oscillator phase step
  localparam logic [ACC_W-1:0] SYSCLK_INC = ACC_W'((SYSCLK_HZ << ACC_W) / CORE_HZ); // System clock step
  // ************************************************************
  // Bus shape
  // ************************************************************
  localparam int SA_W = 20; // Latched address lines
  localparam int LA_LO = 17; // Lowest unlatched address bit
  localparam int DMA_N = 8; // DMA channels
  localparam int IRQ_LO = 2; // Lowest interrupt line
  localparam int IRQ_HI = 15; // Highest interrupt line
  localparam int DMA16_LO = 4; // First 16-bit DMA channel
  localparam logic [3:0] MEM1M_TOP = 4'h0; // Top nibble of first megabyte
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {CY_MEMR = 2'h0, CY_MEMW = 2'h1, CY_IOR = 2'h2, CY_IOW = 2'h3} sibhp_cmd_t;
  typedef enum logic [2:0] {OWN_CPU = 3'h1, OWN_DMA = 3'h2, OWN_REF = 3'h4} sibhp_owner_t;
  typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_ADDR = 4'h2, ST_CMD = 4'h4, ST_END = 4'h8} sibhp_state_t;
endpackage : sibhp_pkg
